/* File: logic/fnps_steer.sv */
// fnps_steer: admits, filters and steers frames between an attached node
// port (or loop) and the switch construct, for point-to-point or loop mode.
// assumes all word streams come from logic on sys_clk_i; no back-pressure.
`timescale 1ns/1ns

module fnps_steer #(
  parameter bit CLS2_EN = 1'b1,
  parameter bit CLS3_EN = 1'b1,
  parameter bit LOCAL_BRIDGE = 1'b0,
  parameter logic [23:0] LC_ADDR = fnps_pkg::CTL_ADDR
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic link_up_i,
  input wire logic mode_ok_i,
  input wire logic mode_fail_i,
  input wire logic peer_bridge_i,
  input fnps_pkg::fnps_word_s lnk_in_i,
  input fnps_pkg::fnps_word_s sw_in_i,
  output fnps_pkg::fnps_word_s sw_o,
  output fnps_pkg::fnps_word_s lc_o,
  output fnps_pkg::fnps_word_s lnk_out_o,
  output fnps_pkg::fnps_word_s icf_o,
  output logic fan_req_o,
  output fnps_pkg::fnps_mode_e mode_o,
  output logic mode_locked_o
);

  // at least one user class must be served
  if (!(CLS2_EN || CLS3_EN)) begin : g_cls_chk
    $error("fnps_steer: no user class enabled");
  end

  typedef enum {
    D_NONE,
    D_SW,
    D_LC,
    D_DROP
  } fnps_dst_e;

  fnps_pkg::fnps_mode_e mode;
  logic locked;
  logic fabric;
  logic loop_m;

  fnps_mode_seek #(
    .LOCAL_BRIDGE(LOCAL_BRIDGE)
  ) u_seek (
    .sys_clk_i(sys_clk_i),
    .resetn_i(resetn_i),
    .link_up_i(link_up_i),
    .ok_i(mode_ok_i),
    .fail_i(mode_fail_i),
    .peer_bridge_i(peer_bridge_i),
    .mode_o(mode),
    .locked_o(locked)
  );

  assign loop_m = (mode == fnps_pkg::M_LOOP);
  assign fabric = loop_m || (mode == fnps_pkg::M_P2P);

  function automatic logic cls_ok(input fnps_pkg::fnps_cls_e c);
    cls_ok = (c == fnps_pkg::C_2 && CLS2_EN) || (c == fnps_pkg::C_3 && CLS3_EN);
  endfunction

  // inbound: link -> switch construct or link control
  fnps_dst_e in_dst_ff;
  fnps_dst_e nxt_in_dst;
  fnps_pkg::fnps_word_s sw_ff;
  fnps_pkg::fnps_word_s nxt_sw;
  fnps_pkg::fnps_word_s lc_ff;
  fnps_pkg::fnps_word_s nxt_lc;
  logic sid_lock_ff;
  logic nxt_sid_lock;
  logic [23:0] sid_ff;
  logic [23:0] nxt_sid;
  fnps_dst_e dst;

  always_comb begin
    nxt_in_dst = in_dst_ff;
    nxt_sw = '0;
    nxt_lc = '0;
    nxt_sid_lock = sid_lock_ff;
    nxt_sid = sid_ff;
    dst = in_dst_ff;
    // forget the attached node whenever the port leaves point-to-point
    if (mode != fnps_pkg::M_P2P) begin
      nxt_sid_lock = 1'b0;
    end
    if (lnk_in_i.vld) begin
      case (lnk_in_i.kind)
        fnps_pkg::K_SOF: begin
          if (!fabric || lnk_in_i.cls == fnps_pkg::C_F) begin
            dst = D_DROP;
          end else if (!cls_ok(lnk_in_i.cls)) begin
            dst = D_DROP;
          end else if (mode == fnps_pkg::M_P2P && sid_lock_ff && lnk_in_i.sid != sid_ff) begin
            dst = D_DROP;
          end else if (lnk_in_i.did == LC_ADDR) begin
            dst = D_LC;
          end else begin
            dst = D_SW;
          end
          // loop mode keeps no source lock, so many loop nodes share the link
          if (mode == fnps_pkg::M_P2P && !sid_lock_ff && dst != D_DROP) begin
            nxt_sid_lock = 1'b1;
            nxt_sid = lnk_in_i.sid;
          end
          nxt_in_dst = dst;
        end
        fnps_pkg::K_DATA,
        fnps_pkg::K_EOF: begin
          if (lnk_in_i.kind == fnps_pkg::K_EOF) begin
            nxt_in_dst = D_NONE;
          end
        end
        fnps_pkg::K_LIP: begin
          dst = D_NONE;
          if (loop_m) begin
            nxt_lc = lnk_in_i;
          end
        end
        default: dst = D_NONE;
      endcase
      // words of a frame follow the choice made at its start
      if (lnk_in_i.kind == fnps_pkg::K_SOF || lnk_in_i.kind == fnps_pkg::K_DATA ||
          lnk_in_i.kind == fnps_pkg::K_EOF) begin
        if (dst == D_SW) begin
          nxt_sw = lnk_in_i;
        end else if (dst == D_LC) begin
          nxt_lc = lnk_in_i;
        end
      end else begin
        // a stray R_RDY would corrupt credit on some other port's link
        nxt_sw.vld = 1'b1;
        nxt_sw.kind = fnps_pkg::K_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      in_dst_ff <= D_NONE;
      sw_ff <= '0;
      lc_ff <= '0;
      sid_lock_ff <= 1'b0;
      sid_ff <= fnps_pkg::ID_ZERO;
    end else begin
      in_dst_ff <= nxt_in_dst;
      sw_ff <= nxt_sw;
      lc_ff <= nxt_lc;
      sid_lock_ff <= nxt_sid_lock;
      sid_ff <= nxt_sid;
    end
  end

  // outbound: switch construct -> link or internal control
  logic out_icf_ff;
  logic nxt_out_icf;
  logic out_drop_ff;
  logic nxt_out_drop;
  fnps_pkg::fnps_word_s lnk_ff;
  fnps_pkg::fnps_word_s nxt_lnk;
  fnps_pkg::fnps_word_s icf_ff;
  fnps_pkg::fnps_word_s nxt_icf;
  fnps_pkg::fnps_mode_e mode_q_ff;
  logic fan_ff;
  logic nxt_fan;
  logic to_icf;
  logic to_drop;

  always_comb begin
    nxt_out_icf = out_icf_ff;
    nxt_out_drop = out_drop_ff;
    nxt_lnk = '0;
    nxt_icf = '0;
    to_icf = out_icf_ff;
    to_drop = out_drop_ff;
    if (sw_in_i.vld && sw_in_i.kind == fnps_pkg::K_SOF) begin
      to_icf = (sw_in_i.cls == fnps_pkg::C_F) || (loop_m && sw_in_i.lmgmt);
      to_drop = !to_icf && !fabric;
      nxt_out_icf = to_icf;
      nxt_out_drop = to_drop;
    end
    if (sw_in_i.vld) begin
      if (sw_in_i.kind == fnps_pkg::K_SOF || sw_in_i.kind == fnps_pkg::K_DATA ||
          sw_in_i.kind == fnps_pkg::K_EOF) begin
        if (to_icf) begin
          nxt_icf = sw_in_i;
        end else if (!to_drop) begin
          nxt_lnk = sw_in_i;
        end
        if (sw_in_i.kind == fnps_pkg::K_EOF) begin
          nxt_out_icf = 1'b0;
          nxt_out_drop = 1'b0;
        end
      end else begin
        nxt_lnk.vld = 1'b1;
        nxt_lnk.kind = fnps_pkg::K_IDLE;
      end
    end
    // announce the fabric address each time loop mode is entered
    nxt_fan = loop_m && (mode_q_ff != fnps_pkg::M_LOOP);
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      out_icf_ff <= 1'b0;
      out_drop_ff <= 1'b0;
      lnk_ff <= '0;
      icf_ff <= '0;
      mode_q_ff <= fnps_pkg::M_NONE;
      fan_ff <= 1'b0;
    end else begin
      out_icf_ff <= nxt_out_icf;
      out_drop_ff <= nxt_out_drop;
      lnk_ff <= nxt_lnk;
      icf_ff <= nxt_icf;
      mode_q_ff <= mode;
      fan_ff <= nxt_fan;
    end
  end

  assign sw_o = sw_ff;
  assign lc_o = lc_ff;
  assign lnk_out_o = lnk_ff;
  assign icf_o = icf_ff;
  assign fan_req_o = fan_ff;
  assign mode_o = mode;
  assign mode_locked_o = locked;

  property p_no_f_out;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    lnk_out_o.vld && lnk_out_o.kind == fnps_pkg::K_SOF |-> lnk_out_o.cls != fnps_pkg::C_F;
  endproperty
  a_no_f_out: assert property (p_no_f_out) else $error("class F sent to node");

  property p_f_blocked;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    lnk_in_i.vld && lnk_in_i.kind == fnps_pkg::K_SOF && lnk_in_i.cls == fnps_pkg::C_F
      |=> !(sw_o.vld && sw_o.kind == fnps_pkg::K_SOF) && !(lc_o.vld && lc_o.kind == fnps_pkg::K_SOF);
  endproperty
  a_f_blocked: assert property (p_f_blocked) else $error("class F admitted");

  property p_prim_idle;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    lnk_in_i.vld && (lnk_in_i.kind == fnps_pkg::K_PSIG || lnk_in_i.kind == fnps_pkg::K_PSEQ)
      |=> sw_o.vld && sw_o.kind == fnps_pkg::K_IDLE;
  endproperty
  a_prim_idle: assert property (p_prim_idle) else $error("primitive not idled");

  property p_own_ctl;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    loop_m && lnk_in_i.vld && lnk_in_i.kind == fnps_pkg::K_SOF && lnk_in_i.did == LC_ADDR &&
      cls_ok(lnk_in_i.cls) |=> lc_o.vld && lc_o.kind == fnps_pkg::K_SOF && !sw_o.vld;
  endproperty
  a_own_ctl: assert property (p_own_ctl) else $error("controller frame misrouted");

  property p_to_switch;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    loop_m && lnk_in_i.vld && lnk_in_i.kind == fnps_pkg::K_SOF && lnk_in_i.did != LC_ADDR &&
      cls_ok(lnk_in_i.cls) |=> sw_o.vld && sw_o.kind == fnps_pkg::K_SOF && sw_o.did == $past(lnk_in_i.did);
  endproperty
  a_to_switch: assert property (p_to_switch) else $error("frame not sent to switch");

  property p_icf_f;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    sw_in_i.vld && sw_in_i.kind == fnps_pkg::K_SOF && sw_in_i.cls == fnps_pkg::C_F
      |=> icf_o.vld && icf_o.kind == fnps_pkg::K_SOF;
  endproperty
  a_icf_f: assert property (p_icf_f) else $error("class F not to internal");

  property p_lmgmt;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    loop_m && sw_in_i.vld && sw_in_i.kind == fnps_pkg::K_SOF && sw_in_i.lmgmt
      |=> icf_o.vld && !lnk_out_o.vld;
  endproperty
  a_lmgmt: assert property (p_lmgmt) else $error("loop service not to internal");

  property p_lip;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    loop_m && lnk_in_i.vld && lnk_in_i.kind == fnps_pkg::K_LIP
      |=> lc_o.vld && lc_o.kind == fnps_pkg::K_LIP ##1 !(sw_o.vld && sw_o.kind == fnps_pkg::K_LIP);
  endproperty
  a_lip: assert property (p_lip) else $error("loop init not to link control");

  property p_fan;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    loop_m && $past(mode) != fnps_pkg::M_LOOP |=> fan_req_o;
  endproperty
  a_fan: assert property (p_fan) else $error("no address notice on loop entry");

endmodule

/* File: logic/fnps_pkg.sv */
// fnps_pkg: word, class and mode types for the fabric node port steering block.
// assumes one clock domain; all users refer to items as fnps_pkg::name.
package fnps_pkg;

  localparam int WORD_W = 32;
  localparam int ID_W = 24;
  // well-known identifier of the port's own controller
  localparam logic [23:0] CTL_ADDR = 24'hfffffe;
  localparam logic [23:0] ID_ZERO = 24'h000000;

  typedef enum logic [2:0] {
    K_IDLE,
    K_PSIG,
    K_PSEQ,
    K_LIP,
    K_SOF,
    K_DATA,
    K_EOF
  } fnps_kind_e;

  typedef enum logic [1:0] {
    C_2,
    C_3,
    C_F,
    C_OTHER
  } fnps_cls_e;

  typedef enum logic [1:0] {
    M_NONE,
    M_LOOP,
    M_ISL,
    M_P2P
  } fnps_mode_e;

  // one transport word; cls, did, sid and lmgmt are meaningful on K_SOF only
  typedef struct packed {
    logic vld;
    fnps_kind_e kind;
    fnps_cls_e cls;
    logic lmgmt;
    logic [ID_W-1:0] did;
    logic [ID_W-1:0] sid;
    logic [WORD_W-1:0] dat;
  } fnps_word_s;

endpackage

/* File: logic/fnps_mode_seek.sv */
// fnps_mode_seek: walks the port through its trial modes until one sticks.
// assumes the trial outcome strobes are one-cycle pulses on sys_clk_i.
`timescale 1ns/1ns
module fnps_mode_seek #(
  parameter bit LOCAL_BRIDGE = 1'b0
) (
  input wire logic sys_clk_i,
  input wire logic resetn_i,
  input wire logic link_up_i,
  input wire logic ok_i,
  input wire logic fail_i,
  input wire logic peer_bridge_i,
  output fnps_pkg::fnps_mode_e mode_o,
  output logic locked_o
);

  fnps_pkg::fnps_mode_e mode_ff;
  fnps_pkg::fnps_mode_e nxt_mode;
  logic locked_ff;
  logic nxt_locked;
  logic pair_bad;

  // a bridge may not pair with a bridge
  assign pair_bad = LOCAL_BRIDGE && peer_bridge_i;

  always_comb begin
    nxt_mode = mode_ff;
    nxt_locked = locked_ff;
    if (!link_up_i) begin
      nxt_mode = fnps_pkg::M_NONE;
      nxt_locked = 1'b0;
    end else if (!locked_ff) begin
      case (mode_ff)
        fnps_pkg::M_NONE: nxt_mode = fnps_pkg::M_LOOP;
        fnps_pkg::M_LOOP: begin
          if (ok_i) begin
            nxt_locked = 1'b1;
          end else if (fail_i) begin
            nxt_mode = fnps_pkg::M_ISL;
          end
        end
        fnps_pkg::M_ISL: begin
          if (ok_i && !pair_bad) begin
            nxt_locked = 1'b1;
          end else if (fail_i || ok_i) begin
            nxt_mode = fnps_pkg::M_P2P;
          end
        end
        fnps_pkg::M_P2P: begin
          if (ok_i) begin
            nxt_locked = 1'b1;
          end else if (fail_i) begin
            nxt_mode = fnps_pkg::M_LOOP;
          end
        end
        default: nxt_mode = fnps_pkg::M_NONE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      mode_ff <= fnps_pkg::M_NONE;
      locked_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      locked_ff <= nxt_locked;
    end
  end

  assign mode_o = mode_ff;
  assign locked_o = locked_ff;

  property p_loop_first;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    link_up_i && mode_ff == fnps_pkg::M_NONE |=> mode_ff == fnps_pkg::M_LOOP;
  endproperty
  a_loop_first: assert property (p_loop_first) else $error("trial did not start in loop");

  property p_bridge_pair;
    @(posedge sys_clk_i) disable iff (!resetn_i)
    link_up_i && !locked_ff && mode_ff == fnps_pkg::M_ISL && pair_bad && ok_i
      |=> !locked_ff && mode_ff == fnps_pkg::M_P2P;
  endproperty
  a_bridge_pair: assert property (p_bridge_pair) else $error("bridge pair accepted");

endmodule

/* File: tb/fnps_node_model.sv */
// fnps_node_model: attached node port, sends inbound words, takes outbound words.
// assumes put is called from the bench's clocked sequence on sys_clk_i.
`timescale 1ns/1ns
module fnps_node_model (
  input wire logic sys_clk_i,
  input fnps_pkg::fnps_word_s rx_i,
  output fnps_pkg::fnps_word_s tx_o,
  output int rx_cnt_o,
  output int drop_cnt_o
);
  initial begin
    tx_o = '0;
    rx_cnt_o = 0;
    drop_cnt_o = 0;
  end

  // one word per call; released line shows the inverse, never a held copy
  task automatic put(input fnps_pkg::fnps_word_s w);
    @(posedge sys_clk_i);
    tx_o <= w;
    @(posedge sys_clk_i);
    tx_o <= fnps_pkg::fnps_word_s'(~w);
  endtask

  always @(posedge sys_clk_i) begin
    if (rx_i.vld === 1'b1 && rx_i.kind === fnps_pkg::K_SOF) begin
      if (rx_i.cls === fnps_pkg::C_F) begin
        drop_cnt_o <= drop_cnt_o + 1;
      end else begin
        rx_cnt_o <= rx_cnt_o + 1;
      end
    end
  end
endmodule

/* File: tb/test_fnps_steer.sv */
// test_fnps_steer: table-driven bench for mode search and frame steering.
// assumes fnps_node_model on the node side; switch side driven here.
`timescale 1ns/1ns
module test_fnps_steer;
  // d dir, k kind, c class, l lmgmt, a did sel, s sid sel, p port, e kind out
  typedef struct packed {
    logic d;
    logic [2:0] k;
    logic [1:0] c;
    logic l;
    logic [1:0] a;
    logic s;
    logic [2:0] p;
    logic [2:0] e;
  } fnps_row_s;
  localparam fnps_row_s ROWS [23] = '{
    '{0,4,1,0,1,0,2,4}, '{0,5,0,0,0,0,2,5}, '{0,6,0,0,0,0,2,6},
    '{0,4,2,0,0,0,0,0}, '{0,5,0,0,0,0,0,0}, '{0,6,0,0,0,0,0,0},
    '{0,4,0,0,2,0,1,4}, '{0,6,0,0,0,0,1,6},
    '{0,4,1,0,0,1,1,4}, '{0,6,0,0,0,1,1,6},
    '{0,4,3,0,0,0,0,0}, '{0,6,0,0,0,0,0,0},
    '{0,1,0,0,0,0,1,0}, '{0,2,0,0,0,0,1,0}, '{0,0,0,0,0,0,1,0},
    '{0,3,0,0,0,0,2,3},
    '{1,4,0,0,0,0,3,4}, '{1,6,0,0,0,0,3,6},
    '{1,4,2,0,0,0,4,4}, '{1,6,0,0,0,0,4,6},
    '{1,4,1,1,0,0,4,4}, '{1,6,0,0,0,0,4,6},
    '{1,1,0,0,0,0,3,0}};
  logic sys_clk = 1'b0;
  logic resetn = 1'b0;
  logic link_up = 1'b0;
  logic ok = 1'b0;
  logic fail = 1'b0;
  logic peer = 1'b0;
  logic fan;
  logic locked;
  fnps_pkg::fnps_word_s lnk_in;
  fnps_pkg::fnps_word_s sw_in = '0;
  fnps_pkg::fnps_word_s sw;
  fnps_pkg::fnps_word_s lc;
  fnps_pkg::fnps_word_s lnk_out;
  fnps_pkg::fnps_word_s icf;
  fnps_pkg::fnps_mode_e mode;
  int miscompares = 0;
  int check_count = 0;
  int fan_cnt = 0;
  int rx_cnt;
  int drop_cnt;

  fnps_steer #(.LOCAL_BRIDGE(1'b1)) u_dut (
    .sys_clk_i(sys_clk), .resetn_i(resetn), .link_up_i(link_up),
    .mode_ok_i(ok), .mode_fail_i(fail), .peer_bridge_i(peer),
    .lnk_in_i(lnk_in), .sw_in_i(sw_in), .sw_o(sw), .lc_o(lc),
    .lnk_out_o(lnk_out), .icf_o(icf), .fan_req_o(fan), .mode_o(mode),
    .mode_locked_o(locked));
  fnps_node_model u_node (
    .sys_clk_i(sys_clk), .rx_i(lnk_out), .tx_o(lnk_in),
    .rx_cnt_o(rx_cnt), .drop_cnt_o(drop_cnt));

  initial begin
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    if (fan === 1'b1) fan_cnt <= fan_cnt + 1;
  end

  task automatic summarize;
    if (miscompares == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t flag %b want %b", $time, got, exp);
    end
  endtask
  task automatic chk_k(input fnps_pkg::fnps_kind_e got, input fnps_pkg::fnps_kind_e exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t word kind %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic chk_m(input fnps_pkg::fnps_mode_e got, input fnps_pkg::fnps_mode_e exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch %0t mode %0d want %0d", $time, got, exp);
    end
  endtask

  function automatic fnps_pkg::fnps_word_s mk(input fnps_row_s r);
    mk = '0;
    mk.vld = 1'b1;
    mk.kind = fnps_pkg::fnps_kind_e'(r.k);
    mk.cls = fnps_pkg::fnps_cls_e'(r.c);
    mk.lmgmt = r.l;
    mk.did = (r.a == 2'h1) ? fnps_pkg::CTL_ADDR : (r.a == 2'h2) ? 24'hfffffd : 24'h010203;
    mk.sid = r.s ? 24'h010a02 : 24'h010a01;
    mk.dat = 32'h000000a5;
  endfunction

  // output stands one cycle, so it is sampled just after the answering edge
  task automatic run_row(input fnps_row_s r);
    fnps_pkg::fnps_word_s w;
    fnps_pkg::fnps_word_s o;
    w = mk(r);
    if (r.d) begin
      @(posedge sys_clk);
      sw_in <= w;
      @(posedge sys_clk);
      sw_in <= fnps_pkg::fnps_word_s'(~w);
    end else begin
      u_node.put(w);
    end
    #1;
    chk1(sw.vld, r.p == 3'h1 || (!r.d && r.k == 3'h3));
    chk1(lc.vld, r.p == 3'h2);
    chk1(lnk_out.vld, r.p == 3'h3);
    chk1(icf.vld, r.p == 3'h4);
    o = (r.p == 3'h1) ? sw : (r.p == 3'h2) ? lc : (r.p == 3'h3) ? lnk_out : icf;
    if (r.p != 3'h0) chk_k(o.kind, fnps_pkg::fnps_kind_e'(r.e));
  endtask

  // spacing keeps each loop entry long enough for its notification
  task automatic step(input logic p_ok, input logic p_fail,
                      input fnps_pkg::fnps_mode_e em, input logic el);
    repeat (3) @(posedge sys_clk);
    ok <= p_ok;
    fail <= p_fail;
    @(posedge sys_clk);
    ok <= 1'b0;
    fail <= 1'b0;
    #1;
    chk_m(mode, em);
    chk1(locked, el);
  endtask

  initial begin
    #100000;
    miscompares++;
    $display("mismatch %0t run limit reached", $time);
    summarize;
  end

  initial begin
    repeat (5) @(posedge sys_clk);
    chk_m(mode, fnps_pkg::M_NONE);
    chk1(locked, 1'b0);
    chk1(sw.vld | lc.vld | lnk_out.vld | icf.vld | fan, 1'b0);
    resetn <= 1'b1;
    @(posedge sys_clk);
    link_up <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk_m(mode, fnps_pkg::M_LOOP);
    step(1'b0, 1'b1, fnps_pkg::M_ISL, 1'b0);
    @(posedge sys_clk);
    peer <= 1'b1;
    step(1'b1, 1'b0, fnps_pkg::M_P2P, 1'b0);
    step(1'b0, 1'b1, fnps_pkg::M_LOOP, 1'b0);
    step(1'b1, 1'b0, fnps_pkg::M_LOOP, 1'b1);
    repeat (3) @(posedge sys_clk);
    chk1(fan_cnt == 2, 1'b1);
    foreach (ROWS[i]) run_row(ROWS[i]);
    @(posedge sys_clk);
    link_up <= 1'b0;
    peer <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_m(mode, fnps_pkg::M_NONE);
    run_row('{0,4,1,0,0,0,0,0});
    @(posedge sys_clk);
    link_up <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk_m(mode, fnps_pkg::M_LOOP);
    step(1'b0, 1'b1, fnps_pkg::M_ISL, 1'b0);
    step(1'b0, 1'b1, fnps_pkg::M_P2P, 1'b0);
    step(1'b1, 1'b0, fnps_pkg::M_P2P, 1'b1);
    run_row('{0,4,1,0,0,0,1,4});
    run_row('{0,6,0,0,0,0,1,6});
    run_row('{0,4,1,0,0,1,0,0});
    run_row('{0,6,0,0,0,1,0,0});
    run_row('{0,3,0,0,0,0,1,0});
    run_row('{1,4,1,1,0,0,3,4});
    run_row('{1,6,0,0,0,0,3,6});
    repeat (2) @(posedge sys_clk);
    #1;
    chk1(drop_cnt == 0, 1'b1);
    chk1(rx_cnt == 2, 1'b1);
    chk1(fan_cnt == 3, 1'b1);
    // mid-run reset: search restarts from loop once released
    @(posedge sys_clk);
    resetn <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_m(mode, fnps_pkg::M_NONE);
    chk1(locked | sw.vld | lc.vld | lnk_out.vld | icf.vld, 1'b0);
    @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk_m(mode, fnps_pkg::M_LOOP);
    chk1(locked, 1'b0);
    summarize;
  end
endmodule
